// ===== design/pfm_pin_mux.sv
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Notes on behaviour
// - After any reset every pin is on its primary function; alternates need programming.
// - Each port line has its own direction bit, independent of the others.
// - Port B line 6 defaults to port use; receive, data, clock-in selectable.
// - Port B line 7 defaults to port use; transmit also carries single-wire receive.
// - Reset pin low in reset role holds all logic in reset.
// - Internal reset releases synchronously after a fixed count of clocks.
// - Every reset returns the pin to its reset role.
// - Clock output selects off at logic 0, master, bus or oscillator clock.
// - Port B line 4 defaults to port use; timer channel or clock output selectable.
module pfm_pin_mux #(
    parameter int RESET_CYCLES = pfm_pkg::RESET_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic port_b_line4_in,
    output logic port_b_line4_out,
    output logic port_b_line4_oe,
    input wire logic port_b_line6_in,
    output logic port_b_line6_out,
    output logic port_b_line6_oe,
    input wire logic port_b_line7_in,
    output logic port_b_line7_out,
    output logic port_b_line7_oe,
    input wire logic watchdog_reset,
    input wire logic sw_reset_req,
    output logic internal_reset_n,
    input wire logic sci_txd,
    input wire logic sci_tx_oe,
    output logic sci_rxd,
    output logic sci_tx_line_in,
    input wire logic i2c_sda_out,
    input wire logic i2c_sda_oe,
    output logic i2c_sda_in,
    input wire logic i2c_scl_out,
    input wire logic i2c_scl_oe,
    output logic i2c_scl_in,
    input wire logic timer_channel_zero_out,
    input wire logic timer_channel_zero_oe,
    output logic timer_channel_zero_in,
    input wire logic master_system_clock,
    input wire logic peripheral_bus_clock,
    input wire logic osc_clock,
    output logic external_clock_input,
    output logic osc_clock_source_sel
);
    import pfm_pkg::*;

    if (RESET_CYCLES < 2 || RESET_CYCLES > 255) begin : g_bad_cycles
        $error("RESET_CYCLES must lie between 2 and 255");
    end

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic [NLINES-1:0] dir;
    logic [NLINES-1:0] out;
    logic [SEL_W-1:0] sel;
    logic [1:0] buffered_clock_output_sel;
    logic in_reset;
    logic [CNT_W-1:0] rst_cnt;

    // Pins and foreign clocks pass two flip-flops; only sync2 is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
        end else begin
            sync1 <= {osc_clock, peripheral_bus_clock, master_system_clock, reset_pin_in,
                      port_b_line7_in, port_b_line6_in, port_b_line4_in};
            sync2 <= sync1;
        end
    end

    wire b4_s = sync2[0];
    wire b6_s = sync2[1];
    wire b7_s = sync2[2];
    wire rst_pin_s = sync2[3];
    wire mstr_s = sync2[4];
    wire ipb_s = sync2[5];
    wire osc_s = sync2[6];

    wire [1:0] b6_fn = sel[B6_FN_LSB +: 2];
    wire [1:0] b7_fn = sel[B7_FN_LSB +: 2];
    wire [1:0] b4_fn = sel[B4_FN_LSB +: 2];
    wire role_a7 = (sel[ROLE_BIT] == ROLE_PORT_A7);

    // Reset sequencing
    wire ext_req = !role_a7 && !rst_pin_s;
    wire reset_req = ext_req || watchdog_reset || sw_reset_req;
    wire [CNT_W-1:0] next_rst_cnt = reset_req ? CNT_W'(RESET_CYCLES) :
        (rst_cnt != '0) ? rst_cnt - 1'b1 : rst_cnt;
    wire next_in_reset = reset_req || (rst_cnt > 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rst_cnt <= CNT_W'(RESET_CYCLES);
            in_reset <= 1'b1;
            internal_reset_n <= 1'b0;
        end else begin
            rst_cnt <= next_rst_cnt;
            in_reset <= next_in_reset;
            internal_reset_n <= !next_in_reset;
        end
    end

    // APB decode
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite && pready;
    wire hit_dir = (paddr == DIR_OFS);
    wire hit_out = (paddr == OUT_OFS);
    wire hit_in = (paddr == IN_OFS);
    wire hit_sel = (paddr == SEL_OFS);
    wire hit_buffered_clock_output = (paddr == BUFFERED_CLOCK_OUTPUT_OFS);
    wire hit_osc = (paddr == OSC_OFS);
    wire mapped = hit_dir || hit_out || hit_in || hit_sel || hit_buffered_clock_output || hit_osc;
    wire [31:0] rd_mux = hit_dir ? {28'h0, dir} :
        hit_out ? {28'h0, out} :
        hit_in ? {28'h0, sync2[3:0]} :
        hit_sel ? {23'h0, sel} :
        hit_buffered_clock_output ? {30'h0, buffered_clock_output_sel} :
        hit_osc ? {31'h0, osc_clock_source_sel} : 32'h0;
    wire [31:0] next_prdata = (setup && !pwrite) ? rd_mux : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= setup;
            pslverr <= setup && !mapped;
        end
    end

    // Every reset, internal or external, restores the configuration
    wire [NLINES-1:0] next_dir = in_reset ? DIR_RST :
        (wr_en && hit_dir) ? pwdata[NLINES-1:0] : dir;
    wire [NLINES-1:0] next_out = in_reset ? OUT_RST :
        (wr_en && hit_out) ? pwdata[NLINES-1:0] : out;
    wire [SEL_W-1:0] next_sel = in_reset ? SEL_RST :
        (wr_en && hit_sel) ? pwdata[SEL_W-1:0] : sel;
    wire [1:0] next_buffered_clock_output_sel = in_reset ? BUFFERED_CLOCK_OUTPUT_RST :
        (wr_en && hit_buffered_clock_output) ? pwdata[1:0] : buffered_clock_output_sel;
    wire next_osc_sel = in_reset ? OSC_RST :
        (wr_en && hit_osc) ? pwdata[0] : osc_clock_source_sel;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir <= DIR_RST;
            out <= OUT_RST;
            sel <= SEL_RST;
            buffered_clock_output_sel <= BUFFERED_CLOCK_OUTPUT_RST;
            osc_clock_source_sel <= OSC_RST;
        end else begin
            dir <= next_dir;
            out <= next_out;
            sel <= next_sel;
            buffered_clock_output_sel <= next_buffered_clock_output_sel;
            osc_clock_source_sel <= next_osc_sel;
        end
    end

    // Pad steering; reserved function codes behave as the port line
    wire b4_t0 = (b4_fn == B4_FN_T0);
    wire b4_buffered_clock_output = (b4_fn == B4_FN_BUFFERED_CLOCK_OUTPUT);
    wire b6_rx = (b6_fn == B6_FN_RX);
    wire b6_sda = (b6_fn == B6_FN_SDA);
    wire b6_external_clock_input = (b6_fn == B6_FN_EXTERNAL_CLOCK_INPUT);
    wire b7_tx = (b7_fn == B7_FN_TX);
    wire b7_scl = (b7_fn == B7_FN_SCL);
    // Sampled copy of the chosen source, so the pad is retimed to pclk
    wire buffered_clock_output_src = (buffered_clock_output_sel == BUFFERED_CLOCK_OUTPUT_MSTR) ? mstr_s :
        (buffered_clock_output_sel == BUFFERED_CLOCK_OUTPUT_IPB) ? ipb_s :
        (buffered_clock_output_sel == BUFFERED_CLOCK_OUTPUT_OSC) ? osc_s : 1'b0;

    wire next_b4_out = b4_t0 ? timer_channel_zero_out :
        b4_buffered_clock_output ? buffered_clock_output_src : out[LINE_B4];
    wire next_b4_oe = !in_reset && (b4_t0 ? timer_channel_zero_oe :
        b4_buffered_clock_output ? 1'b1 : dir[LINE_B4]);
    wire next_b6_out = b6_sda ? i2c_sda_out : out[LINE_B6];
    wire next_b6_oe = !in_reset && (b6_sda ? i2c_sda_oe :
        (b6_rx || b6_external_clock_input) ? 1'b0 : dir[LINE_B6]);
    wire next_b7_out = b7_tx ? sci_txd : b7_scl ? i2c_scl_out : out[LINE_B7];
    wire next_b7_oe = !in_reset && (b7_tx ? sci_tx_oe :
        b7_scl ? i2c_scl_oe : dir[LINE_B7]);
    // Open drain: only ever pulls low
    wire next_a7_oe = !in_reset && role_a7 && dir[LINE_A7] && !out[LINE_A7];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_line4_out <= 1'b0;
            port_b_line4_oe <= 1'b0;
            port_b_line6_out <= 1'b0;
            port_b_line6_oe <= 1'b0;
            port_b_line7_out <= 1'b0;
            port_b_line7_oe <= 1'b0;
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b0;
        end else begin
            port_b_line4_out <= next_b4_out;
            port_b_line4_oe <= next_b4_oe;
            port_b_line6_out <= next_b6_out;
            port_b_line6_oe <= next_b6_oe;
            port_b_line7_out <= next_b7_out;
            port_b_line7_oe <= next_b7_oe;
            reset_pin_out <= 1'b0;
            reset_pin_oe <= next_a7_oe;
        end
    end

    // Peripheral inputs idle at their inactive level when not routed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sci_rxd <= 1'b1;
            sci_tx_line_in <= 1'b1;
            i2c_sda_in <= 1'b1;
            i2c_scl_in <= 1'b1;
            timer_channel_zero_in <= 1'b0;
            external_clock_input <= 1'b0;
        end else begin
            sci_rxd <= b6_rx ? b6_s : 1'b1;
            sci_tx_line_in <= b7_tx ? b7_s : 1'b1;
            i2c_sda_in <= b6_sda ? b6_s : 1'b1;
            i2c_scl_in <= b7_scl ? b7_s : 1'b1;
            timer_channel_zero_in <= b4_t0 ? b4_s : 1'b0;
            external_clock_input <= (b6_external_clock_input && osc_clock_source_sel) ? b6_s : 1'b0;
        end
    end

    // Helper for checking the release count
    logic [CNT_W-1:0] low_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt <= '0;
        end else if (reset_req) begin
            low_cnt <= '0;
        end else if (low_cnt != '1) begin
            low_cnt <= low_cnt + 1'b1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pads_in_reset_a: assert property (!internal_reset_n |=>
        !port_b_line4_oe && !port_b_line6_oe && !port_b_line7_oe && !reset_pin_oe)
        else $error("pad driven while internal reset active");
    release_count_a: assert property ($rose(internal_reset_n) |->
        low_cnt == CNT_W'(RESET_CYCLES))
        else $error("internal reset released after wrong count");
    release_hold_a: assert property (reset_req |=> !internal_reset_n [*2])
        else $error("internal reset released too early");
    pin_reset_a: assert property ((!role_a7 && !rst_pin_s) |=> !internal_reset_n)
        else $error("reset pin low did not reset");
    a7_ignore_a: assert property ((role_a7 && !watchdog_reset && !sw_reset_req
        && internal_reset_n && rst_cnt == '0) |=> internal_reset_n)
        else $error("reset asserted while pin is port line");
    a7_drain_a: assert property (reset_pin_oe |->
        !reset_pin_out && $past(role_a7 && dir[LINE_A7] && !out[LINE_A7]))
        else $error("port A line 7 not open drain");
    role_default_a: assert property (!internal_reset_n |=>
        sel[ROLE_BIT] == ROLE_RESET && sel == SEL_RST)
        else $error("pin not back in reset role");
    gpio_dir_a: assert property ((sel == SEL_RST && !in_reset) |=>
        port_b_line6_oe == $past(dir[LINE_B6]) && port_b_line7_oe == $past(dir[LINE_B7]))
        else $error("port direction not independent");
    buffered_clock_output_off_a: assert property ((b4_buffered_clock_output && buffered_clock_output_sel == BUFFERED_CLOCK_OUTPUT_OFF && !in_reset) |=>
        !port_b_line4_out && port_b_line4_oe)
        else $error("disabled clock output not at 0");
    buffered_clock_output_mstr_a: assert property ((b4_buffered_clock_output && buffered_clock_output_sel == BUFFERED_CLOCK_OUTPUT_MSTR) |=>
        port_b_line4_out == $past(mstr_s))
        else $error("clock output not following master clock");
    tx_route_a: assert property ((b7_tx && !in_reset) |=>
        port_b_line7_out == $past(sci_txd) && port_b_line7_oe == $past(sci_tx_oe)
        && sci_tx_line_in == $past(b7_s))
        else $error("transmit not routed to line 7");
    rx_route_a: assert property (b6_rx |=> sci_rxd == $past(b6_s) && !port_b_line6_oe)
        else $error("receive not routed from line 6");
    timer_route_a: assert property ((b4_t0 && !in_reset) |=>
        port_b_line4_oe == $past(timer_channel_zero_oe))
        else $error("timer channel not routed to line 4");

    ext_reset_c: cover property (!role_a7 && !rst_pin_s ##1 !internal_reset_n);
    buffered_clock_output_on_c: cover property (b4_buffered_clock_output && buffered_clock_output_sel == BUFFERED_CLOCK_OUTPUT_OSC && port_b_line4_oe);
    a7_pull_c: cover property (reset_pin_oe);
    single_wire_c: cover property (b7_tx && !sci_tx_oe ##1 !port_b_line7_oe);
endmodule : pfm_pin_mux

// ===== include/pfm_pkg.sv
package pfm_pkg;
    // Register byte offsets on the APB port
    localparam logic [7:0] DIR_OFS = 8'h00;
    localparam logic [7:0] OUT_OFS = 8'h04;
    localparam logic [7:0] IN_OFS = 8'h08;
    localparam logic [7:0] SEL_OFS = 8'h0c;
    localparam logic [7:0] BUFFERED_CLOCK_OUTPUT_OFS = 8'h10;
    localparam logic [7:0] OSC_OFS = 8'h14;
    // Bit of each pin line in the direction, output and input registers
    localparam int LINE_B4 = 0;
    localparam int LINE_B6 = 1;
    localparam int LINE_B7 = 2;
    localparam int LINE_A7 = 3;
    localparam int NLINES = 4;
    // Pin-function select register layout
    localparam int B6_FN_LSB = 0;
    localparam int B7_FN_LSB = 2;
    localparam int B4_FN_LSB = 4;
    localparam int ROLE_BIT = 8;
    localparam int SEL_W = 9;
    // Function codes; code 0 is the general-purpose port line
    localparam logic [1:0] FN_GPIO = 2'h0;
    localparam logic [1:0] B6_FN_RX = 2'h1;
    localparam logic [1:0] B6_FN_SDA = 2'h2;
    localparam logic [1:0] B6_FN_EXTERNAL_CLOCK_INPUT = 2'h3;
    localparam logic [1:0] B7_FN_TX = 2'h1;
    localparam logic [1:0] B7_FN_SCL = 2'h2;
    localparam logic [1:0] B4_FN_T0 = 2'h1;
    localparam logic [1:0] B4_FN_BUFFERED_CLOCK_OUTPUT = 2'h2;
    // Buffered clock output sources
    localparam logic [1:0] BUFFERED_CLOCK_OUTPUT_OFF = 2'h0;
    localparam logic [1:0] BUFFERED_CLOCK_OUTPUT_MSTR = 2'h1;
    localparam logic [1:0] BUFFERED_CLOCK_OUTPUT_IPB = 2'h2;
    localparam logic [1:0] BUFFERED_CLOCK_OUTPUT_OSC = 2'h3;
    localparam logic ROLE_RESET = 1'b0;
    localparam logic ROLE_PORT_A7 = 1'b1;
    // Values after reset
    localparam logic [NLINES-1:0] DIR_RST = 4'h0;
    localparam logic [NLINES-1:0] OUT_RST = 4'h0;
    localparam logic [SEL_W-1:0] SEL_RST = 9'h000;
    localparam logic [1:0] BUFFERED_CLOCK_OUTPUT_RST = 2'h0;
    localparam logic OSC_RST = 1'b0;
    // Synchroniser vector {osc, ipb, mstr, rst_pin, b7, b6, b4}; reset pin idles high
    localparam int SYNC_W = 7;
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h08;
    // Internal reset stretch after the last reset request
    localparam int RESET_CYCLES_DEF = 16;
    localparam int CNT_W = 8;
endpackage : pfm_pkg

// ===== tb/pfm_pin_mux_bench.sv
`timescale 1ns/10ps
module pfm_pin_mux_bench;
    import pfm_pkg::*;
    localparam int RC = 6;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic ext_rst = 1'b1, ext4 = 1'b0, ext6 = 1'b0, ext7 = 1'b0;
    logic watchdog_reset = 1'b0, sw_reset_req = 1'b0;
    logic sci_txd = 1'b0, sci_tx_oe = 1'b0, i2c_sda_out = 1'b0, i2c_sda_oe = 1'b0;
    logic i2c_scl_out = 1'b0, i2c_scl_oe = 1'b0;
    logic timer_channel_zero_out = 1'b0, timer_channel_zero_oe = 1'b0;
    logic master_system_clock = 1'b0, peripheral_bus_clock = 1'b0, osc_clock = 1'b0;
    logic [31:0] prdata, q, seed = 32'h95d3;
    logic pready, pslverr, err, reset_pin_out, reset_pin_oe, internal_reset_n;
    logic port_b_line4_out, port_b_line4_oe, port_b_line6_out, port_b_line6_oe;
    logic port_b_line7_out, port_b_line7_oe, sci_rxd, sci_tx_line_in, i2c_sda_in;
    logic i2c_scl_in, timer_channel_zero_in, external_clock_input, osc_clock_source_sel;
    int fails = 0, samples_checked = 0, n;
    // Open-drain reset pad with pull-up; other pads follow whoever drives them
    wire logic reset_pin_in = reset_pin_oe ? 1'b0 : ext_rst;
    wire logic port_b_line4_in = port_b_line4_oe ? port_b_line4_out : ext4;
    wire logic port_b_line6_in = port_b_line6_oe ? port_b_line6_out : ext6;
    wire logic port_b_line7_in = port_b_line7_oe ? port_b_line7_out : ext7;
    always #10 pclk = ~pclk;
    pfm_pin_mux #(.RESET_CYCLES(RC)) dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .port_b_line4_in,
        .port_b_line4_out, .port_b_line4_oe, .port_b_line6_in, .port_b_line6_out,
        .port_b_line6_oe, .port_b_line7_in, .port_b_line7_out, .port_b_line7_oe,
        .watchdog_reset, .sw_reset_req, .internal_reset_n, .sci_txd, .sci_tx_oe,
        .sci_rxd, .sci_tx_line_in, .i2c_sda_out, .i2c_sda_oe, .i2c_sda_in, .i2c_scl_out,
        .i2c_scl_oe, .i2c_scl_in, .timer_channel_zero_out, .timer_channel_zero_oe,
        .timer_channel_zero_in, .master_system_clock, .peripheral_bus_clock, .osc_clock,
        .external_clock_input, .osc_clock_source_sel
    );
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function automatic logic [31:0] selw(logic [1:0] b6, logic [1:0] b7, logic [1:0] b4);
        return 32'(b6) << B6_FN_LSB | 32'(b7) << B7_FN_LSB | 32'(b4) << B4_FN_LSB;
    endfunction : selw
    function automatic logic pad(logic oe, logic o, logic e);
        return oe ? o : e;
    endfunction : pad
    function automatic logic clk_exp(logic [1:0] src);
        case (src)
            BUFFERED_CLOCK_OUTPUT_MSTR: return master_system_clock;
            BUFFERED_CLOCK_OUTPUT_IPB: return peripheral_bus_clock;
            BUFFERED_CLOCK_OUTPUT_OSC: return osc_clock;
            default: return 1'b0;
        endcase
    endfunction : clk_exp
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, q, exp);
    endtask : rdc
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask : cyc
    task automatic wait_rst(input logic lvl, input int bound);
        n = 0;
        while (internal_reset_n !== lvl && n < bound) begin
            @(posedge pclk);
            n++;
        end
        if (internal_reset_n !== lvl) fails++;
    endtask : wait_rst
    // Fresh random pad and peripheral levels, then time to cross the synchronisers
    task automatic stim();
        logic [31:0] v;
        v = rnd();
        {ext4, ext6, ext7, sci_txd, sci_tx_oe, i2c_sda_out, i2c_sda_oe} <= v[6:0];
        {i2c_scl_out, i2c_scl_oe, timer_channel_zero_out, timer_channel_zero_oe} <= v[10:7];
        {master_system_clock, peripheral_bus_clock, osc_clock} <= v[13:11];
        cyc(6);
    endtask : stim
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    initial begin
        #400000;
        fails++;
        final_report();
    end
    initial begin
        logic [3:0] d, o, e;
        cyc(4);
        presetn <= 1'b1;
        wait_rst(1'b1, 40);
        check("por stretch", 32'(n >= RC && n <= RC + 2), 32'h1);
        check("pads idle", 32'({reset_pin_oe, port_b_line4_oe, port_b_line6_oe}),
            0);
        rdc("dir", DIR_OFS, 32'(DIR_RST));
        rdc("out", OUT_OFS, 32'(OUT_RST));
        rdc("sel", SEL_OFS, 32'(SEL_RST));
        rdc("buffered_clock_output", BUFFERED_CLOCK_OUTPUT_OFS, 32'(BUFFERED_CLOCK_OUTPUT_RST));
        rdc("osc", OSC_OFS, 32'(OSC_RST));
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped", {q[30:0], err}, 32'h1);
        apb(1'b1, 8'h02, 32'hf);
        check("unaligned", 32'(err), 32'h1);
        for (int i = 0; i < 8; i++) begin
            {d, o, e} = 12'(rnd());
            {ext7, ext6, ext4} <= e[2:0];
            apb(1'b1, DIR_OFS, {28'h0, 1'b0, d[2:0]});
            apb(1'b1, OUT_OFS, {28'h0, o});
            apb(1'b1, IN_OFS, 32'h0);
            cyc(5);
            check("line oe", 32'({port_b_line7_oe, port_b_line6_oe, port_b_line4_oe}),
                32'(d[2:0]));
            e = {1'b1, (d[2:0] & o[2:0]) | (~d[2:0] & e[2:0])};
            rdc("in", IN_OFS, 32'(e));
        end
        apb(1'b1, DIR_OFS, 32'h0);
        apb(1'b1, SEL_OFS, selw(B6_FN_RX, B7_FN_TX, B4_FN_T0));
        for (int i = 0; i < 4; i++) begin
            stim();
            check("rxd", 32'({sci_rxd, i2c_sda_in, i2c_scl_in}),
                32'({ext6, 2'b11}));
            check("l7 drv", 32'({port_b_line7_oe, port_b_line7_out}),
                32'({sci_tx_oe, sci_txd}));
            check("tx in", 32'(sci_tx_line_in),
                32'(pad(sci_tx_oe, sci_txd, ext7)));
            check("l4 drv", 32'({port_b_line4_oe, port_b_line4_out}),
                32'({timer_channel_zero_oe, timer_channel_zero_out}));
            check("t0 in", 32'(timer_channel_zero_in),
                32'(pad(timer_channel_zero_oe, timer_channel_zero_out, ext4)));
        end
        apb(1'b1, SEL_OFS, selw(B6_FN_SDA, B7_FN_SCL, B4_FN_BUFFERED_CLOCK_OUTPUT));
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, BUFFERED_CLOCK_OUTPUT_OFS, 32'(s));
            stim();
            check("sda", 32'({port_b_line6_oe, port_b_line6_out, i2c_sda_in, sci_rxd}),
                32'({i2c_sda_oe, i2c_sda_out, pad(i2c_sda_oe, i2c_sda_out, ext6),
                1'b1}));
            check("scl", 32'({port_b_line7_oe, port_b_line7_out, i2c_scl_in}),
                32'({i2c_scl_oe, i2c_scl_out,
                pad(i2c_scl_oe, i2c_scl_out, ext7)}));
            check("clk out", 32'({port_b_line4_oe, port_b_line4_out}),
                32'({1'b1, clk_exp(2'(s))}));
        end
        apb(1'b1, OSC_OFS, 32'h1);
        apb(1'b1, SEL_OFS, selw(B6_FN_EXTERNAL_CLOCK_INPUT, FN_GPIO, FN_GPIO));
        for (int i = 0; i < 3; i++) begin
            stim();
            check("clk in", 32'({external_clock_input, osc_clock_source_sel}),
                32'({ext6, 1'b1}));
        end
        apb(1'b1, OSC_OFS, 32'h0);
        stim();
        check("clk in off", 32'({external_clock_input, osc_clock_source_sel}),
            0);
        apb(1'b1, DIR_OFS, 32'h7);
        ext_rst <= 1'b0;
        wait_rst(1'b0, 8);
        check("pin reset", 32'(n <= 5 && internal_reset_n === 1'b0), 32'h1);
        cyc(4);
        check("held", 32'({internal_reset_n, port_b_line4_oe, port_b_line7_oe}),
            0);
        ext_rst <= 1'b1;
        wait_rst(1'b1, 40);
        check("pin stretch", 32'(n >= RC && n <= RC + 4), 32'h1);
        rdc("dir cleared", DIR_OFS, 32'(DIR_RST));
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, SEL_OFS, 32'h1 << ROLE_BIT);
            apb(1'b1, DIR_OFS, 32'h8);
            cyc(8);
            check("a7 drive", 32'({reset_pin_oe, reset_pin_out, internal_reset_n}),
                32'h5);
            apb(1'b1, OUT_OFS, 32'h8);
            ext_rst <= 1'b0;
            cyc(8);
            check("a7 no reset", 32'({reset_pin_oe, internal_reset_n}), 32'h1);
            apb(1'b0, IN_OFS, 32'h0);
            check("a7 in", 32'(q[LINE_A7]), 0);
            {sw_reset_req, watchdog_reset} <= k[0] ? 2'b10 : 2'b01;
            @(posedge pclk);
            {sw_reset_req, watchdog_reset} <= 2'b00;
            wait_rst(1'b0, 8);
            check("req reset", 32'(internal_reset_n), 0);
            ext_rst <= 1'b1;
            wait_rst(1'b1, 40);
            rdc("role back", SEL_OFS, 32'(SEL_RST));
            // Pin must reset the chip again once back in its reset role
            ext_rst <= 1'b0;
            wait_rst(1'b0, 8);
            check("reset role", 32'(internal_reset_n), 0);
            ext_rst <= 1'b1;
            wait_rst(1'b1, 40);
        end
        final_report();
    end
endmodule : pfm_pin_mux_bench
